/* src/irq_mask_pkg.sv */
// constants, field layouts and state types of the interrupt mask bank
// assumes one 200 MHz clock and an internal byte-wide register port
// How it works
// - mask bit 0 blocks, 1 passes
// - general mask at 0x0c, bit 7 fault
// - general bits 6/5: battery over/undervoltage
// - general bits 4/3: thermal, low-power change
// - general bit 2 wake, resets to one
// - general bits 1/0: safe level, bus range
// - port mask 0x0d, bits 5..3, 7:6 unused
// - port bits 2..0: plug supply, overcurrent, abort
// - charger mask 0x0e, bits 4/3, 7:5 unused
// - bits 2/1 gate run rise/fall edges
// - charger bit 0 gates contact timeout
// - protection mask 0x0f, bits 1/0 only
// - accessory mask 0x10, bits 4..0
// - pin is interrupt only when select is one
// - running flag edges are the gated events
package irq_mask_pkg;

    localparam logic [7:0] OFF_GEN  = 8'h0c;
    localparam logic [7:0] OFF_PORT = 8'h0d;
    localparam logic [7:0] OFF_CHG  = 8'h0e;
    localparam logic [7:0] OFF_PROT = 8'h0f;
    localparam logic [7:0] OFF_ACC  = 8'h10;

    localparam logic [7:0] RST_GEN  = 8'h04;
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [7:0] RST_CHG  = 8'h00;
    localparam logic [7:0] RST_PROT = 8'h00;
    localparam logic [7:0] RST_ACC  = 8'h00;

    // implemented bits of each register, the rest read zero
    localparam logic [7:0] BITS_GEN  = 8'hff;
    localparam logic [7:0] BITS_PORT = 8'h3f;
    localparam logic [7:0] BITS_CHG  = 8'h1f;
    localparam logic [7:0] BITS_PROT = 8'h03;
    localparam logic [7:0] BITS_ACC  = 8'h1f;

    // flat source vector: {acc[4:0], prot[1:0], chg[4:0], port[5:0], gen}
    localparam int SRC_W     = 26;
    localparam int POS_GEN   = 0;
    localparam int POS_PORT  = 8;
    localparam int POS_CHG   = 14;
    localparam int POS_PROT  = 19;
    localparam int POS_ACC   = 21;
    localparam int POS_RISE  = 16;
    localparam int POS_FALL  = 15;

    typedef struct packed {
        logic [7:0] gen;
        logic [7:0] port;
        logic [7:0] chg;
        logic [7:0] prot;
        logic [7:0] acc;
    } mask_bank_t;

    typedef struct packed {
        mask_bank_t masks;
        logic [7:0] rdata;
        logic       run_d;
        logic       irq_oe;
    } top_state_t;

    localparam top_state_t TOP_RESET = '{
        masks  : '{gen: RST_GEN, port: RST_PORT, chg: RST_CHG,
                   prot: RST_PROT, acc: RST_ACC},
        rdata  : 8'h00,
        run_d  : 1'b0,
        irq_oe : 1'b0
    };

endpackage : irq_mask_pkg

/* src/event_latch.sv */
// sticky pending flags, one per status source
// assumes set and clear pulses come from logic on the same clock
`timescale 1ns/10ps
module event_latch
    import irq_mask_pkg::*;
#(
    parameter int W = SRC_W
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] pend_o
);

    logic [W-1:0] pend_reg;
    logic [W-1:0] pend_next;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // a set in the clearing cycle wins
            assign pend_next[g] = set_i[g] | (pend_reg[g] & ~clr_i[g]);
        end
    endgenerate

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    assign pend_o = pend_reg;

endmodule : event_latch

/* src/irq_mask_top.sv */
// interrupt mask bank with pending flags and the open-drain irq pin
// assumes status events, flag levels and the register port are
// produced by logic on clk_i; the pad resolves the open-drain wire
`timescale 1ns/10ps
module irq_mask_top
    import irq_mask_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [7:0]        reg_rdata_o,
    input  wire logic [7:0]        general_evt_i,
    input  wire logic [5:0]        port_evt_i,
    input  wire logic              charger_type_evt_i,
    input  wire logic              proprietary_type_evt_i,
    input  wire logic              contact_timeout_evt_i,
    input  wire logic              detection_running_flag_i,
    input  wire logic [1:0]        protection_evt_i,
    input  wire logic [4:0]        accessory_evt_i,
    input  wire logic [SRC_W-1:0]  pend_clear_i,
    input  wire logic              irq_pin_function_select_i,
    input  wire logic              flag_source_i,
    output logic                   irq_pin_o,
    output logic                   irq_pin_oe_o
);

    top_state_t             state_reg;
    top_state_t             state_next;
    logic       [SRC_W-1:0] src_evt;
    logic       [SRC_W-1:0] pend;
    logic       [SRC_W-1:0] mask_vec;
    logic                   run_rise;
    logic                   run_fall;
    logic                   any_unmasked;

    ////////////////////////////////////////////////////////////////////
    // source events and pending flags
    assign run_rise = detection_running_flag_i & ~state_reg.run_d;
    assign run_fall = ~detection_running_flag_i & state_reg.run_d;

    assign src_evt = {
        accessory_evt_i,
        protection_evt_i,
        charger_type_evt_i,
        proprietary_type_evt_i,
        run_rise,
        run_fall,
        contact_timeout_evt_i,
        port_evt_i,
        general_evt_i
    };

    event_latch #(
        .W (SRC_W)
    ) u_pend (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .set_i    (src_evt),
        .clr_i    (pend_clear_i),
        .pend_o   (pend)
    );

    // the mask vector lines up with the source vector
    assign mask_vec = {
        state_reg.masks.acc[4:0],
        state_reg.masks.prot[1:0],
        state_reg.masks.chg[4:0],
        state_reg.masks.port[5:0],
        state_reg.masks.gen
    };

    assign any_unmasked = |(pend & mask_vec);

    ////////////////////////////////////////////////////////////////////
    // register port, pin drive
    always_comb begin
        state_next       = state_reg;
        state_next.run_d = detection_running_flag_i;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFF_GEN:  state_next.masks.gen  = reg_wdata_i & BITS_GEN;
                OFF_PORT: state_next.masks.port = reg_wdata_i & BITS_PORT;
                OFF_CHG:  state_next.masks.chg  = reg_wdata_i & BITS_CHG;
                OFF_PROT: state_next.masks.prot = reg_wdata_i & BITS_PROT;
                OFF_ACC:  state_next.masks.acc  = reg_wdata_i & BITS_ACC;
                default:  state_next.masks      = state_reg.masks;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFF_GEN:  state_next.rdata = state_reg.masks.gen;
                OFF_PORT: state_next.rdata = state_reg.masks.port;
                OFF_CHG:  state_next.rdata = state_reg.masks.chg;
                OFF_PROT: state_next.rdata = state_reg.masks.prot;
                OFF_ACC:  state_next.rdata = state_reg.masks.acc;
                default:  state_next.rdata = 8'h00;
            endcase
        end
        // interrupt mode or plain flag mode
        if (irq_pin_function_select_i) begin
            state_next.irq_oe = any_unmasked;
        end else begin
            state_next.irq_oe = flag_source_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= TOP_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o  = state_reg.rdata;
    assign irq_pin_oe_o = state_reg.irq_oe;
    // open drain: the pin is only ever pulled low
    assign irq_pin_o    = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_irq_unmasked_pend: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        irq_pin_function_select_i && any_unmasked |=> irq_pin_oe_o)
        else $error("unmasked pending event did not drive the pin");

    chk_masked_stays_quiet: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        irq_pin_function_select_i && !(|(pend & mask_vec))
            |=> !irq_pin_oe_o)
        else $error("pin driven with every pending event masked");

    chk_flag_mode_pin: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !irq_pin_function_select_i |=> irq_pin_oe_o == $past(flag_source_i))
        else $error("pin does not follow the flag in flag mode");

    chk_gen_write_read: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == OFF_GEN && !reg_rd_i
            ##1 reg_rd_i && reg_addr_i == OFF_GEN && !reg_wr_i
            |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("general mask read back differs from write");

    chk_port_unused_zero: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_rd_i && reg_addr_i == OFF_PORT |=> reg_rdata_o[7:6] == 2'b00)
        else $error("port mask unused bits read nonzero");

    chk_chg_unused_zero: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_rd_i && reg_addr_i == OFF_CHG |=> reg_rdata_o[7:5] == 3'b000)
        else $error("charger mask unused bits read nonzero");

    chk_prot_unused_zero: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_rd_i && reg_addr_i == OFF_PROT |=> reg_rdata_o[7:2] == 6'h00)
        else $error("protection mask unused bits read nonzero");

    chk_acc_unused_zero: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_rd_i && reg_addr_i == OFF_ACC |=> reg_rdata_o[7:5] == 3'b000)
        else $error("accessory mask unused bits read nonzero");

    chk_run_rise_pend: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(detection_running_flag_i) |=> pend[POS_RISE])
        else $error("running flag rise not latched");

    chk_run_fall_pend: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $fell(detection_running_flag_i) |=> pend[POS_FALL])
        else $error("running flag fall not latched");

    // every source pulse must leave its pending flag set
    chk_event_latched: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        |src_evt |=> (pend & $past(src_evt)) == $past(src_evt))
        else $error("source event did not set its pending flag");

    chk_clear_drops_pend: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        |(pend_clear_i & ~src_evt)
            |=> (pend & $past(pend_clear_i & ~src_evt)) == '0)
        else $error("cleared pending flag still set");

    chk_rdata_holds: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    chk_gen_write_lands: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == OFF_GEN
            |=> state_reg.masks.gen == $past(reg_wdata_i))
        else $error("general mask write did not land");

    chk_port_write_lands: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == OFF_PORT
            |=> state_reg.masks.port == ($past(reg_wdata_i) & BITS_PORT))
        else $error("port mask write did not land");

    chk_acc_write_lands: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == OFF_ACC
            |=> state_reg.masks.acc == ($past(reg_wdata_i) & BITS_ACC))
        else $error("accessory mask write did not land");

    cov_run_fall_seen: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $fell(detection_running_flag_i));

    cov_irq_raised: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        irq_pin_function_select_i && $rose(irq_pin_oe_o));

    cov_flag_mode: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !irq_pin_function_select_i && irq_pin_oe_o);

    cov_set_and_clear: cover property (
        @(posedge clk_i) disable iff (!arst_n_i)
        |(src_evt & pend_clear_i));

endmodule : irq_mask_top

/* tb/irq_host_model.sv */
// host side of the interrupt line: a pull-up on the open-drain wire
// assumes the device only ever pulls the line low through its enable
`timescale 1ns/10ps
module irq_host_model (
    input  wire logic irq_pin_oe_i,
    input  wire logic irq_pin_i,
    output logic      irq_line_n_o
);
    // a released line floats up to the pull-up level
    assign irq_line_n_o = irq_pin_oe_i ? irq_pin_i : 1'b1;
endmodule : irq_host_model

/* tb/charger_detector_interrupt_masks_test.sv */
// self-checking bench of the interrupt mask bank
// assumes the byte strobe register port and pulse events of the notes
`timescale 1ns/10ps
module charger_detector_interrupt_masks_test
    import irq_mask_pkg::*;
;
    logic             clk_i = 1'b0;
    logic             arst_n_i = 1'b0;
    logic [7:0]       reg_addr_i = 8'h00;
    logic [7:0]       reg_wdata_i = 8'h00;
    logic             reg_wr_i = 1'b0;
    logic             reg_rd_i = 1'b0;
    logic [7:0]       reg_rdata_o;
    logic [25:0]      ev = '0;
    logic             run_flag = 1'b0;
    logic [SRC_W-1:0] pend_clear_i = '0;
    logic             sel = 1'b1;
    logic             flag_source_i = 1'b0;
    logic             irq_pin_o;
    logic             irq_pin_oe_o;
    logic             irq_line_n;
    int               n_mismatch = 0;
    int               checks = 0;
    logic [7:0] offs [5] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
    logic [7:0] rstv [5] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] impl [5] = '{8'hff, 8'h3f, 8'h1f, 8'h03, 8'h1f};

    irq_mask_top u_irq_mask_top (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .general_evt_i(ev[7:0]), .port_evt_i(ev[13:8]),
        .charger_type_evt_i(ev[18]), .proprietary_type_evt_i(ev[17]),
        .contact_timeout_evt_i(ev[14]),
        .detection_running_flag_i(run_flag),
        .protection_evt_i(ev[20:19]), .accessory_evt_i(ev[25:21]),
        .pend_clear_i(pend_clear_i), .irq_pin_function_select_i(sel),
        .flag_source_i(flag_source_i), .irq_pin_o(irq_pin_o),
        .irq_pin_oe_o(irq_pin_oe_o)
    );
    irq_host_model u_irq_host_model (
        .irq_pin_oe_i(irq_pin_oe_o), .irq_pin_i(irq_pin_o),
        .irq_line_n_o(irq_line_n)
    );

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic chk(input string what, input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // each access leaves one idle edge so strobes never toggle twice at once
    task automatic wr(input logic [7:0] a, d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a, exp);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        chk(what, reg_rdata_o, exp);
        tick(1);
    endtask : rd_chk
    // bits 16 and 15 come from the run flag edges, the rest are pulses
    task automatic fire(input int i);
        if (i == 16) run_flag = 1'b1;
        else if (i == 15) run_flag = 1'b0;
        else ev = 26'h1 << i;
        tick(1);
        ev = '0;
    endtask : fire
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    task automatic test_registers;
        for (int k = 0; k < 5; k++) begin
            rd_chk("reset value", offs[k], rstv[k]);
            wr(offs[k], 8'hff);
            rd_chk("written bits", offs[k], impl[k]);
            wr(offs[k], 8'h00);
            rd_chk("cleared", offs[k], 8'h00);
        end
        wr(8'h11, 8'hff);
        rd_chk("unmapped", 8'h11, 8'h00);
    endtask : test_registers
    task automatic test_source_gating;
        int k;
        int b;
        for (int i = 25; i >= 0; i--) begin
            k = i < 8 ? 0 : i < 14 ? 1 : i < 19 ? 2 : i < 21 ? 3 : 4;
            b = i - (k == 0 ? 0 : k == 1 ? 8 : k == 2 ? 14 : k == 3 ? 19 : 21);
            fire(i);
            tick(3);
            chk("masked pin", {7'h00, irq_pin_oe_o}, 8'h00);
            wr(offs[k], 8'h01 << b);
            tick(2);
            chk("unmasked pin", {7'h00, irq_pin_oe_o}, 8'h01);
            chk("host line", {7'h00, irq_line_n}, 8'h00);
            pend_clear_i = 26'h1 << i;
            tick(1);
            pend_clear_i = '0;
            tick(2);
            chk("cleared pin", {7'h00, irq_pin_oe_o}, 8'h00);
            wr(offs[k], 8'h00);
        end
    endtask : test_source_gating
    task automatic test_pin_mode;
        sel = 1'b0;
        flag_source_i = 1'b1;
        tick(2);
        chk("flag high", {7'h00, irq_pin_oe_o}, 8'h01);
        chk("flag line", {7'h00, irq_line_n}, 8'h00);
        flag_source_i = 1'b0;
        wr(8'h0c, 8'h04);
        fire(2);
        tick(2);
        chk("flag mode event", {7'h00, irq_pin_oe_o}, 8'h00);
        sel = 1'b1;
        tick(2);
        chk("irq mode event", {7'h00, irq_pin_oe_o}, 8'h01);
        pend_clear_i = 26'h1 << 2;
        tick(1);
        pend_clear_i = '0;
    endtask : test_pin_mode
    // reset in mid-run must drop pending flags and restore the masks
    task automatic test_reset_midrun;
        wr(8'h0c, 8'hff);
        fire(7);
        tick(1);
        chk("pin before reset", {7'h00, irq_pin_oe_o}, 8'h01);
        arst_n_i = 1'b0;
        tick(2);
        chk("pin in reset", {7'h00, irq_pin_oe_o}, 8'h00);
        chk("rdata in reset", reg_rdata_o, 8'h00);
        arst_n_i = 1'b1;
        tick(1);
        rd_chk("gen after reset", 8'h0c, 8'h04);
        wr(8'h0c, 8'h80);
        tick(2);
        chk("pend after reset", {7'h00, irq_pin_oe_o}, 8'h00);
        wr(8'h0c, 8'h00);
    endtask : test_reset_midrun
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        tick(1);
        test_registers();
        wr(8'h0c, 8'h00);
        test_source_gating();
        test_pin_mode();
        test_reset_midrun();
        tally_and_finish();
    end
    initial begin
        #50000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : charger_detector_interrupt_masks_test
